// ==== rtl/isr_pkg.sv ====
// Constants and types for the status reporting block
// Contract
// - Request service only on enabled rising bit
// - Request bit stays set until polled
// - Serial poll clears the request bit
// - Serial poll returns current status byte
// - Input queue holds 1024 bytes in order
// - Output queue holds 274 bytes in order
// - Bit four shows output queue not empty
// - Message terminator discards pending output bytes
// - Error queue holds 30 codes, oldest first
// - Full error queue: newest becomes -350
// - Clear status empties flags and error queue
// - Clear status keeps masks, cancels completion wait
// - Event mask write loads eight bit mask
// - Event mask cleared only at power-on
// - Event flag bit layout; bits 6,1 zero
// - Event flag query returns then clears
// - Completion flag after prior input processed
// - Completion query also queues ASCII 1
// - Completion wait cancelled by clears, reset
// - Identity answer has four comma fields
// - Summary bit six from enabled status bits
// - Status byte query changes no bit
package isr_pkg;
   // Queue depths and error code width
   localparam int IN_DEPTH  = 1024;
   localparam int OUT_DEPTH = 274;
   localparam int ERR_DEPTH = 30;
   localparam int ERR_W     = 16;
   // Event flag bit positions
   localparam int EVF_PON = 7;
   localparam int EVF_CME = 5;
   localparam int EVF_EXE = 4;
   localparam int EVF_DDE = 3;
   localparam int EVF_QYE = 2;
   localparam int EVF_OPC = 0;
   // Status byte bit positions
   localparam int STB_OPER = 7;
   localparam int STB_RQS  = 6;
   localparam int STB_ESB  = 5;
   localparam int STB_MAV  = 4;
   localparam int STB_QUES = 3;
   localparam int STB_SRC  = 0;
   // Reset values and codes
   localparam logic [7:0]       EVF_RST      = 8'h80;
   localparam logic [7:0]       MASK_RST     = 8'h00;
   localparam logic [ERR_W-1:0] ERR_TOO_MANY = 16'hfea2;
   localparam logic [7:0]       ASCII_ONE    = 8'h31;

   typedef enum logic [3:0] {
      CMD_NOP       = 4'h0,
      CMD_CLEAR     = 4'h1,
      CMD_EVMASK_WR = 4'h2,
      CMD_EVMASK_RD = 4'h3,
      CMD_EVFLAG_RD = 4'h4,
      CMD_STB_RD    = 4'h5,
      CMD_SRMASK_WR = 4'h6,
      CMD_SRMASK_RD = 4'h7,
      CMD_OPC       = 4'h8,
      CMD_OPC_Q     = 4'h9,
      CMD_IDN_Q     = 4'ha,
      CMD_RESET     = 4'hb
   } isr_cmd_e;

   typedef enum logic [1:0] {
      ST_IDLE      = 2'b00,
      ST_OPC_WAIT  = 2'b01,
      ST_OPCQ_WAIT = 2'b10,
      ST_IDN       = 2'b11
   } isr_st_e;
endpackage

// ==== rtl/isr_fifo_if.sv ====
// Queue port bundle between the status block and its FIFOs
`timescale 1ns/1ns
interface isr_fifo_if #(parameter int W = 8);
   logic         wr_valid;
   logic         wr_ready;
   logic [W-1:0] wr_data;
   logic         ovw;
   logic         flush;
   logic         rd_valid;
   logic         rd_ready;
   logic [W-1:0] rd_data;
   modport fifo (input wr_valid, wr_data, ovw, flush, rd_ready, output wr_ready, rd_valid, rd_data);
   modport user (output wr_valid, wr_data, ovw, flush, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

// ==== rtl/isr_fifo.sv ====
// Circular FIFO with flush and newest-entry overwrite
`timescale 1ns/1ns
module isr_fifo
   import isr_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Queue port
   isr_fifo_if.fifo q
);
   localparam int AW = $clog2(DEPTH);
   typedef logic [AW-1:0] isr_ptr_t;
   typedef struct packed {
      isr_ptr_t    wp;
      isr_ptr_t    rp;
      logic [AW:0] cnt;
   } isr_fifo_s;

   isr_fifo_s    s_q;
   isr_fifo_s    s_d;
   logic [W-1:0] mem [DEPTH];
   logic         push;
   logic         pop;

   // Depth need not be a power of two
   function automatic isr_ptr_t nxt(input isr_ptr_t p);
      return (p == isr_ptr_t'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign q.wr_ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign q.rd_valid = (s_q.cnt != '0);
   assign q.rd_data  = mem[s_q.rp];
   assign push       = q.wr_valid && q.wr_ready;
   assign pop        = q.rd_valid && q.rd_ready;

   always_comb begin
      s_d = s_q;
      if (q.flush) begin
         s_d = '0;
      end else begin
         if (push) begin
            s_d.wp = nxt(s_q.wp);
         end
         if (pop) begin
            s_d.rp = nxt(s_q.rp);
         end
         s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Memory carries no reset; valid data is tracked by the count
   always_ff @(posedge clk) begin
      if (push && !q.flush) begin
         mem[s_q.wp] <= q.wr_data;
      end else if (q.ovw && !q.flush && q.rd_valid) begin
         mem[(s_q.wp == '0) ? isr_ptr_t'(DEPTH - 1) : s_q.wp - 1'b1] <= q.wr_data;
      end
   end
endmodule // isr_fifo

// ==== rtl/isr_status.sv ====
// Status byte, event flags, service request and message queues
`timescale 1ns/1ns
module isr_status
   import isr_pkg::*;
#(
   // Identity text; value is arbitrary
   parameter int                  ID_LEN  = 16,
   parameter logic [8*ID_LEN-1:0] ID_TEXT = "NOVENDOR,XM1,0,A"
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Listener bytes into input queue
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [7:0]       in_byte,
   input  wire logic             in_end,
   // Command processor drain of input queue
   output logic                  pq_valid,
   input  wire logic             pq_ready,
   output logic [7:0]            pq_byte,
   output logic                  pq_end,
   input  wire logic             proc_busy,
   // Decoded common commands
   input  wire logic             cmd_valid,
   output logic                  cmd_ready,
   input  isr_cmd_e              cmd_op,
   input  wire logic [7:0]       cmd_arg,
   // Query answers
   output logic                  qry_valid,
   output logic [7:0]            qry_data,
   // Response bytes from processor
   input  wire logic             resp_valid,
   output logic                  resp_ready,
   input  wire logic [7:0]       resp_byte,
   // Talker bytes out of output queue
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [7:0]            out_byte,
   // Event pulses
   input  wire logic             ev_cmd_err,
   input  wire logic             ev_exe_err,
   input  wire logic             ev_dev_err,
   input  wire logic             ev_qry_err,
   // Error queue
   input  wire logic             err_push,
   input  wire logic [ERR_W-1:0] err_code,
   input  wire logic             err_rd,
   output logic                  err_valid,
   output logic [ERR_W-1:0]      err_data,
   // Summary inputs from other status groups
   input  wire logic             sum_oper,
   input  wire logic             sum_quest,
   input  wire logic             sum_source,
   // Interface clear and serial poll
   input  wire logic             dev_clear,
   input  wire logic             poll,
   output logic [7:0]            poll_data,
   output logic                  srq
);
   // Index width reaches one past the last byte
   localparam int IW = $clog2(ID_LEN + 1);

   // Whole register bank; one next-state copy below
   typedef struct packed {
      isr_st_e       st;
      logic [7:0]    evf;
      logic [7:0]    evmask;
      logic [7:0]    srmask;
      logic          rqs;
      logic [7:0]    stb_prev;
      logic [7:0]    poll;
      logic [7:0]    qry;
      logic          qry_vld;
      logic [IW-1:0] idx;
   } isr_top_s;

   isr_top_s   s_q;
   isr_top_s   s_d;
   logic [7:0] stb_base;
   logic [7:0] rise;
   logic       esb;
   logic       mss;
   logic       cmd_go;
   logic       done_in;
   logic       int_push;
   logic [7:0] int_byte;
   logic       opc_set;
   logic       flag_clr;
   logic       cancel;
   logic       clear_go;
   logic       msg_end;
   logic       err_full;

   // Status byte with bit six filled in; poll and query differ only there
   function automatic logic [7:0] stb_fill(input logic [7:0] base, input logic bit6);
      logic [7:0] v;
      v          = base;
      v[STB_RQS] = bit6;
      return v;
   endfunction

   // Queue bundles; the storage side sits in the queue modules
   isr_fifo_if #(.W(9))     iq ();
   isr_fifo_if #(.W(8))     oq ();
   isr_fifo_if #(.W(ERR_W)) eq ();

   // Input queue
   isr_fifo #(
      .W     (9),
      .DEPTH (IN_DEPTH)
   ) u_in_q (
      .clk (clk),
      .rst (rst),
      .q   (iq.fifo)
   );

   // Output queue
   isr_fifo #(
      .W     (8),
      .DEPTH (OUT_DEPTH)
   ) u_out_q (
      .clk (clk),
      .rst (rst),
      .q   (oq.fifo)
   );

   // Error queue
   isr_fifo #(
      .W     (ERR_W),
      .DEPTH (ERR_DEPTH)
   ) u_err_q (
      .clk (clk),
      .rst (rst),
      .q   (eq.fifo)
   );

   // Input queue glue
   assign iq.wr_valid = in_valid;
   assign iq.wr_data  = {in_end, in_byte};
   assign iq.ovw      = 1'b0;
   assign iq.flush    = dev_clear;
   assign iq.rd_ready = pq_ready;
   assign in_ready    = iq.wr_ready;
   assign pq_valid    = iq.rd_valid;
   assign pq_byte     = iq.rd_data[7:0];
   assign pq_end      = iq.rd_data[8];

   // New message terminator discards stale replies
   assign msg_end     = in_valid && iq.wr_ready && in_end;
   assign oq.flush    = msg_end || dev_clear;
   assign oq.ovw      = 1'b0;
   // Internal replies take the write port first
   assign resp_ready  = oq.wr_ready && !int_push && cmd_ready;
   assign oq.wr_valid = int_push || (resp_valid && resp_ready);
   assign oq.wr_data  = int_push ? int_byte : resp_byte;
   assign oq.rd_ready = out_ready;
   assign out_valid   = oq.rd_valid;
   assign out_byte    = oq.rd_data;

   // Full queue keeps its oldest entries, newest slot marks overflow
   assign clear_go    = cmd_go && (cmd_op == CMD_CLEAR);
   assign eq.wr_valid = err_push;
   assign err_full    = !eq.wr_ready;
   assign eq.ovw      = err_push && err_full;
   assign eq.wr_data  = err_full ? ERR_TOO_MANY : err_code;
   assign eq.flush    = clear_go;
   assign eq.rd_ready = err_rd;
   assign err_valid   = eq.rd_valid;
   assign err_data    = eq.rd_data;

   // Status byte without bit six
   assign esb = |(s_q.evf & s_q.evmask);
   always_comb begin
      stb_base           = 8'h00;
      stb_base[STB_OPER] = sum_oper;
      stb_base[STB_ESB]  = esb;
      stb_base[STB_MAV]  = oq.rd_valid;
      stb_base[STB_QUES] = sum_quest;
      stb_base[STB_SRC]  = sum_source;
   end
   // Summary leaves bit six out of its own mask
   assign mss       = |(stb_base & s_q.srmask);
   assign rise      = stb_base & ~s_q.stb_prev & s_q.srmask;
   // Completion query and identity own the output queue, so they block commands
   assign cmd_ready = (s_q.st == ST_IDLE) || (s_q.st == ST_OPC_WAIT);
   assign cmd_go    = cmd_valid && cmd_ready;
   // Processed means queue drained and parser idle
   assign done_in   = !iq.rd_valid && !proc_busy;

   always_comb begin
      s_d          = s_q;
      s_d.qry_vld  = 1'b0;
      // Edge detect compares against last cycle's byte
      s_d.stb_prev = stb_base;
      int_push     = 1'b0;
      int_byte     = 8'h00;
      opc_set      = 1'b0;
      flag_clr     = 1'b0;
      cancel       = dev_clear;

      // Serial poll answer and request clear
      if (poll) begin
         s_d.poll          = stb_fill(stb_base, s_q.rqs);
         s_d.rqs           = 1'b0;
      end
      // A new request wins over a poll in the same cycle
      if (|rise) begin
         s_d.rqs = 1'b1;
      end

      // Completion work waits for the parser to drain; identity bytes wait only for queue room
      case (s_q.st)
         ST_OPC_WAIT: begin
            if (done_in) begin
               opc_set = 1'b1;
               s_d.st  = ST_IDLE;
            end
         end
         ST_OPCQ_WAIT: begin
            if (done_in && oq.wr_ready) begin
               opc_set  = 1'b1;
               int_push = 1'b1;
               int_byte = ASCII_ONE;
               s_d.st   = ST_IDLE;
            end
         end
         ST_IDN: begin
            int_byte = ID_TEXT[8*(ID_LEN-1-int'(s_q.idx)) +: 8];
            // One identity byte per cycle while room remains
            if (oq.wr_ready) begin
               int_push = 1'b1;
               s_d.idx  = s_q.idx + 1'b1;
               if (s_q.idx == IW'(ID_LEN - 1)) begin
                  s_d.st = ST_IDLE;
               end
            end
         end
         default: begin
         end
      endcase

      if (cmd_go) begin
         case (cmd_op)
            CMD_CLEAR: begin
               flag_clr = 1'b1;
               cancel   = 1'b1;
            end
            CMD_RESET: begin
               cancel = 1'b1;
            end
            CMD_EVMASK_WR: begin
               s_d.evmask = cmd_arg;
            end
            CMD_EVMASK_RD: begin
               s_d.qry     = s_q.evmask;
               s_d.qry_vld = 1'b1;
            end
            CMD_EVFLAG_RD: begin
               // Read returns the old value; pulses this cycle survive
               s_d.qry     = s_q.evf;
               s_d.qry_vld = 1'b1;
               flag_clr    = 1'b1;
            end
            CMD_STB_RD: begin
               s_d.qry     = stb_fill(stb_base, mss);
               s_d.qry_vld      = 1'b1;
            end
            CMD_SRMASK_WR: begin
               // Bit six is the summary itself and cannot be enabled
               s_d.srmask          = cmd_arg;
               s_d.srmask[STB_RQS] = 1'b0;
            end
            CMD_SRMASK_RD: begin
               s_d.qry     = s_q.srmask;
               s_d.qry_vld = 1'b1;
            end
            CMD_OPC: begin
               // A completion already due this cycle keeps its flag
               s_d.st  = ST_OPC_WAIT;
            end
            CMD_OPC_Q: begin
               s_d.st  = ST_OPCQ_WAIT;
            end
            CMD_IDN_Q: begin
               s_d.idx = '0;
               s_d.st  = ST_IDN;
            end
            default: begin
            end
         endcase
      end

      // Clears and reset drop a pending completion wait
      if (cancel) begin
         if (s_q.st != ST_IDN) begin
            s_d.st = ST_IDLE;
         end
         opc_set = 1'b0;
         if (int_push && (s_q.st == ST_OPCQ_WAIT)) begin
            int_push = 1'b0;
         end
      end

      // Events set after the clear so none is lost; bits 6 and 1 stay zero
      s_d.evf = flag_clr ? 8'h00 : s_q.evf;
      if (ev_cmd_err) begin
         s_d.evf[EVF_CME] = 1'b1;
      end
      if (ev_exe_err) begin
         s_d.evf[EVF_EXE] = 1'b1;
      end
      if (ev_dev_err) begin
         s_d.evf[EVF_DDE] = 1'b1;
      end
      if (ev_qry_err) begin
         s_d.evf[EVF_QYE] = 1'b1;
      end
      if (opc_set) begin
         s_d.evf[EVF_OPC] = 1'b1;
      end
   end

   // Power-on flag set by reset; masks cleared only here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q          <= '0;
         s_q.st       <= ST_IDLE;
         s_q.evf      <= EVF_RST;
         s_q.evmask   <= MASK_RST;
         s_q.srmask   <= MASK_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Answers come straight from the register bank
   assign qry_valid = s_q.qry_vld;
   assign qry_data  = s_q.qry;
   assign poll_data = s_q.poll;
   assign srq       = s_q.rqs;
endmodule // isr_status

// ==== verif/isr_status_properties.sv ====
// Port assertions for the status block
`timescale 1ns/1ns
module isr_status_properties
   import isr_pkg::*;
(
   // Clock and reset
   input wire logic             clk,
   input wire logic             rst,
   // Queues, commands and polls
   input wire logic             in_valid, in_ready, in_end, pq_valid, out_valid, dev_clear,
   input wire logic             cmd_valid, cmd_ready, qry_valid, err_push, err_valid, poll, srq,
   input isr_cmd_e              cmd_op,
   input wire logic [ERR_W-1:0] err_code, err_data,
   input wire logic [7:0]       poll_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_rqs_hold; srq && !poll |=> srq; endproperty
   a_rqs_hold: assert property (p_rqs_hold) else $error("request dropped");
   property p_poll_rqs; poll |=> poll_data[STB_RQS] == $past(srq); endproperty
   a_poll_rqs: assert property (p_poll_rqs) else $error("poll bit6 wrong");
   property p_poll_mav; poll |=> poll_data[STB_MAV] == $past(out_valid); endproperty
   a_poll_mav: assert property (p_poll_mav) else $error("poll bit4 wrong");
   property p_term; in_valid && in_ready && in_end |=> !out_valid; endproperty
   a_term: assert property (p_term) else $error("reply kept");
   property p_qry; cmd_valid && cmd_ready && cmd_op inside {CMD_EVMASK_RD, CMD_EVFLAG_RD, CMD_STB_RD}
      |=> qry_valid; endproperty
   a_qry: assert property (p_qry) else $error("no answer");
   property p_qry_src; qry_valid |-> $past(cmd_valid) && $past(cmd_ready); endproperty
   a_qry_src: assert property (p_qry_src) else $error("stray answer");
   property p_opcq; cmd_valid && cmd_ready && cmd_op == CMD_OPC_Q |=> !cmd_ready; endproperty
   a_opcq: assert property (p_opcq) else $error("input not held");
   property p_dclr; dev_clear |=> !pq_valid && !out_valid; endproperty
   a_dclr: assert property (p_dclr) else $error("queues kept");
   property p_err; err_push && !err_valid && !cmd_valid |=> err_valid && err_data == $past(err_code); endproperty
   a_err: assert property (p_err) else $error("error head wrong");
endmodule // isr_status_properties
bind isr_status isr_status_properties i_isr_status_properties (.*);

// ==== verif/isr_ctl_model.sv ====
// Controller model: serial polls and talker reads
`timescale 1ns/1ns
module isr_ctl_model (
   // Clock
   input wire logic       clk,
   // Talker and poll lines
   input wire logic       out_valid,
   input wire logic [7:0] out_byte,
   input wire logic [7:0] poll_data,
   output logic           out_ready = 1'b0,
   output logic           poll = 1'b0
);
   // Bounded wait so a lost reply cannot hang the run
   task automatic rd(output logic [7:0] v);
      int n = 0;
      @(negedge clk);
      while (!out_valid && n < 3000) begin
         @(negedge clk);
         n++;
      end
      out_ready = 1'b1;
      v         = out_byte;
      @(negedge clk);
      out_ready = 1'b0;
   endtask
   task automatic sp(output logic [7:0] v);
      @(negedge clk);
      poll = 1'b1;
      @(negedge clk);
      poll = 1'b0;
      v    = poll_data;
   endtask
endmodule // isr_ctl_model

// ==== verif/tb_isr_status.sv ====
// Bench for the status block
`timescale 1ns/1ns
module tb_isr_status;
   import isr_pkg::*;
   logic clk, rst, in_valid, in_ready, in_end, pq_valid, pq_ready, pq_end, proc_busy;
   logic cmd_valid, cmd_ready, qry_valid, resp_valid, resp_ready, out_valid, out_ready;
   logic ev_cmd_err, ev_exe_err, ev_dev_err, ev_qry_err, err_push, err_rd, err_valid;
   logic sum_oper, sum_quest, sum_source, dev_clear, poll, srq;
   logic [7:0]       in_byte, pq_byte, cmd_arg, qry_data, resp_byte, out_byte, poll_data, qd, b;
   logic [ERR_W-1:0] err_code, err_data;
   isr_cmd_e         cmd_op;
   int               err_total, cmp_count;
   isr_status i_isr_status (.*);
   isr_ctl_model i_isr_ctl_model (.*);
   task chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Only issued while idle or waiting on a completion, so ready is high at the edge
   task cmd(input isr_cmd_e op, input logic [7:0] a);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op    = op;
      cmd_arg   = a;
      @(negedge clk);
      cmd_valid = 1'b0;
      qd        = qry_data;
   endtask
   task automatic pl(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task t_flags;
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h80);
      cmd(CMD_EVMASK_RD, 8'h00);
      chk(qd, 8'h00);
      cmd(CMD_EVMASK_WR, 8'h04);
      pl(ev_cmd_err);
      cmd(CMD_STB_RD, 8'h00);
      chk(qd, 8'h00);
      pl(ev_qry_err);
      pl(ev_exe_err);
      pl(ev_dev_err);
      cmd(CMD_STB_RD, 8'h00);
      chk(qd, 8'h20);
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h3c);
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h00);
      $display("test flags done");
   endtask
   task t_srq;
      cmd(CMD_SRMASK_WR, 8'h41);
      cmd(CMD_SRMASK_RD, 8'h00);
      chk(qd, 8'h01);
      sum_quest = 1'b1;
      repeat (3) @(negedge clk);
      chk(srq, 1'b0);
      sum_source = 1'b1;
      repeat (3) @(negedge clk);
      chk(srq, 1'b1);
      i_isr_ctl_model.sp(b);
      chk(b, 8'h49);
      chk(srq, 1'b0);
      cmd(CMD_STB_RD, 8'h00);
      chk(qd, 8'h49);
      chk(srq, 1'b0);
      {sum_quest, sum_source} = 2'b00;
      sum_oper = 1'b1;
      cmd(CMD_STB_RD, 8'h00);
      chk(qd, 8'h80);
      sum_oper = 1'b0;
      $display("test srq done");
   endtask
   task t_outq;
      resp_valid = 1'b1;
      for (int i = 0; i < OUT_DEPTH; i++) begin
         resp_byte = i[7:0];
         chk(resp_ready, 1'b1);
         @(negedge clk);
      end
      resp_valid = 1'b0;
      chk(resp_ready, 1'b0);
      i_isr_ctl_model.rd(b);
      chk(b, 8'h00);
      i_isr_ctl_model.sp(b);
      chk(b[STB_MAV], 1'b1);
      in_end = 1'b1;
      pl(in_valid);
      chk(out_valid, 1'b0);
      i_isr_ctl_model.sp(b);
      chk(b[STB_MAV], 1'b0);
      chk(pq_end, 1'b1);
      in_end = 1'b0;
      pl(pq_ready);
      $display("test outq done");
   endtask
   task t_inq;
      in_valid = 1'b1;
      for (int i = 0; i < IN_DEPTH; i++) begin
         in_byte = i[7:0];
         chk(in_ready, 1'b1);
         @(negedge clk);
      end
      in_valid = 1'b0;
      chk(in_ready, 1'b0);
      pq_ready = 1'b1;
      for (int i = 0; i < IN_DEPTH; i++) begin
         chk(pq_byte, i[7:0]);
         @(negedge clk);
      end
      pq_ready = 1'b0;
      chk(pq_valid, 1'b0);
      $display("test inq done");
   endtask
   task t_err;
      err_push = 1'b1;
      for (int i = 1; i <= ERR_DEPTH + 2; i++) begin
         err_code = i[15:0];
         @(negedge clk);
      end
      err_push = 1'b0;
      err_rd   = 1'b1;
      for (int i = 1; i <= ERR_DEPTH; i++) begin
         chk(err_data, i < ERR_DEPTH ? i[15:0] : 16'hfea2);
         @(negedge clk);
      end
      err_rd = 1'b0;
      chk(err_valid, 1'b0);
      pl(err_push);
      pl(ev_exe_err);
      pl(resp_valid);
      cmd(CMD_CLEAR, 8'h00);
      chk(err_valid, 1'b0);
      chk(out_valid, 1'b1);
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h00);
      cmd(CMD_EVMASK_RD, 8'h00);
      chk(qd, 8'h04);
      i_isr_ctl_model.rd(b);
      chk(b, 8'h11);
      $display("test err done");
   endtask
   task t_opc;
      proc_busy = 1'b1;
      cmd(CMD_OPC_Q, 8'h00);
      repeat (8) @(negedge clk);
      chk(out_valid, 1'b0);
      proc_busy = 1'b0;
      i_isr_ctl_model.rd(b);
      chk(b, 8'h31);
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h01);
      proc_busy = 1'b1;
      cmd(CMD_OPC, 8'h00);
      pl(dev_clear);
      proc_busy = 1'b0;
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h00);
      proc_busy = 1'b1;
      cmd(CMD_OPC, 8'h00);
      repeat (4) @(negedge clk);
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h00);
      proc_busy = 1'b0;
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h01);
      proc_busy = 1'b1;
      cmd(CMD_OPC, 8'h00);
      cmd(CMD_RESET, 8'h00);
      proc_busy = 1'b0;
      cmd(CMD_EVFLAG_RD, 8'h00);
      chk(qd, 8'h00);
      $display("test opc done");
   endtask
   task t_idn;
      int         c;
      logic [7:0] p;
      c = 0;
      p = 8'h00;
      cmd(CMD_IDN_Q, 8'h00);
      for (int i = 0; i < 16; i++) begin
         i_isr_ctl_model.rd(b);
         if (c == 2 && p == 8'h2c) begin
            chk(b, 8'h30);
         end
         if (c == 2 && p == 8'h30) begin
            chk(b, 8'h2c);
         end
         if (b == 8'h2c) begin
            c++;
         end
         p = b;
      end
      chk(16'(c), 16'h0003);
      chk(out_valid, 1'b0);
      $display("test idn done");
   endtask
   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Whole run is a few thousand cycles
   initial begin
      #100000;
      err_total++;
      final_report;
   end
   initial begin
      {in_valid, in_end, pq_ready, proc_busy, cmd_valid, resp_valid, dev_clear} = '0;
      {ev_cmd_err, ev_exe_err, ev_dev_err, ev_qry_err, err_push, err_rd} = '0;
      {sum_oper, sum_quest, sum_source, in_byte, cmd_arg, resp_byte, err_code} = '0;
      cmd_op = CMD_NOP;
      rst    = 1'b1;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_flags;
      t_srq;
      t_outq;
      t_inq;
      t_err;
      t_opc;
      t_idn;
      final_report;
   end
endmodule // tb_isr_status
